// ### inc/adsq_pkg.sv
// Constants, register layout and carrier types for the converter sequencer.
// Assumes one system clock that also paces the converter.
// Functional notes
// RULE_01 - Each conversion yields an eight-bit result.
// RULE_02 - Sampled input resolved bit by bit, successively.
// RULE_03 - Three-bit field picks one of eight inputs.
// RULE_04 - Writing one to start bit begins conversion.
// RULE_05 - Start bit clears itself after one cycle.
// RULE_06 - Completion loads result, sets done and flag.
// RULE_07 - Done bit reads zero while converting.
// RULE_08 - Conversion lasts twenty-one times six clocks; the sequencer takes 127 clocks from sample start to done.
// RULE_09 - Software powers converter off before power-down.
// RULE_10 - Software stays quiet during a conversion.
// RULE_11 - Software sets analog pins to input mode.
// RULE_12 - Software writes zero to reserved control bits.
// RULE_13 - Interrupt flag cleared only by software.
// RULE_14 - Result holds until next completion, reads harmless.
package adsq_pkg;
  localparam int unsigned RES_W = 8;
  localparam int unsigned CH_W = 3;
  localparam logic [7:0] CTRL_ADDR = 8'h84;
  localparam logic [7:0] RESULT_ADDR = 8'h85;
  localparam int unsigned POWER_BIT = 6;
  localparam int unsigned CH_LSB = 2;
  localparam int unsigned GO_BIT = 1;
  localparam int unsigned DONE_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam int unsigned CONV_MULT = 21;
  localparam int unsigned CONV_DIV = 6;
  localparam int unsigned CONV_CYCLES = CONV_MULT * CONV_DIV;
  localparam int unsigned STEP_CYCLES = CONV_CYCLES / (RES_W + 6);
  localparam int unsigned SAMPLE_CYCLES = CONV_CYCLES - RES_W * STEP_CYCLES;
  localparam int unsigned CNT_W = 7;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adsq_sfr_req_t;

  typedef struct packed {
    logic power_on;
    logic [CH_W-1:0] channel;
  } adsq_analog_t;
endpackage

// ### rtl/adsq_sar.sv
// Successive-approximation register: one trial bit resolved per step.
// Assumes the comparator input is settled when step_in is high.
`timescale 1ns/1ps
`default_nettype none
module adsq_sar #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic load_in,
  input wire logic step_in,
  input wire logic comp_in,
  output logic [WIDTH-1:0] trial_out,
  output logic [WIDTH-1:0] result_out,
  output logic done_out
);
  // The first trial code needs a set top bit above at least one cleared bit.
  if (WIDTH < 2) begin : g_bad_width
    $error("adsq_sar needs a width of at least two bits");
  end

  logic [WIDTH-1:0] trial_ff;
  logic [WIDTH-1:0] mask_ff;
  logic [WIDTH-1:0] result_ff;
  logic done_ff;
  wire logic [WIDTH-1:0] kept = comp_in ? trial_ff : (trial_ff & ~mask_ff);
  wire logic [WIDTH-1:0] nxt_mask = mask_ff >> 1;
  wire logic [WIDTH-1:0] msb = {1'b1, {(WIDTH-1){1'b0}}};
  wire logic last_step = step_in && mask_ff[0];

  // The comparator high means the held input is at or above the trial level.
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      trial_ff <= '0;
      mask_ff <= '0;
      result_ff <= '0;
      done_ff <= 1'b0;
    end else if (ce_in) begin
      done_ff <= last_step;
      if (load_in) begin
        trial_ff <= msb;
        mask_ff <= msb;
      end else if (step_in && mask_ff != '0) begin
        trial_ff <= kept | nxt_mask; // RULE_02
        mask_ff <= nxt_mask;
      end
      if (last_step) begin
        result_ff <= kept; // RULE_01
      end
    end
  end

  assign trial_out = trial_ff;
  assign result_out = result_ff;
  assign done_out = done_ff;
endmodule
`default_nettype wire

// ### rtl/adsq_ctrl.sv
// Converter sequencer: control and result registers, channel select,
// sample phase and stepping of the approximation register.
// Assumes a special function register port synchronous to clock_in and an
// external ladder and comparator fed from trial_code_out.
`timescale 1ns/1ps
`default_nettype none
module adsq_ctrl #(
  parameter int unsigned RES_WIDTH = 8,
  parameter int unsigned CHANNELS = 8
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire adsq_pkg::adsq_sfr_req_t sfr_req_in,
  input wire logic comparator_in,
  input wire logic irq_flag_set_in,
  input wire logic irq_flag_clear_in,
  output logic [7:0] sfr_rdata_out,
  output adsq_pkg::adsq_analog_t analog_out,
  output logic sample_hold_out,
  output logic [RES_WIDTH-1:0] trial_code_out,
  output logic converter_irq_request_out
);
  import adsq_pkg::*;

  if (RES_WIDTH != RES_W || CHANNELS != (1 << CH_W)) begin : g_bad_params
    $error("adsq_ctrl supports only an 8-bit result and eight channels");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } adsq_state_t;

  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);

  adsq_state_t state_ff;
  adsq_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic power_on_ff;
  logic [CH_W-1:0] channel_ff;
  logic conversion_go_ff;
  logic conversion_done_ff;
  logic converter_irq_flag_ff;
  logic [7:0] rdata_ff;
  logic sample_hold_ff;
  logic [RES_WIDTH-1:0] result_value;
  logic sar_done;

  // Register decode.
  wire logic ctrl_wr = sfr_req_in.wr && (sfr_req_in.addr == CTRL_ADDR);
  wire logic ctrl_rd = sfr_req_in.rd && (sfr_req_in.addr == CTRL_ADDR);
  wire logic result_rd = sfr_req_in.rd && (sfr_req_in.addr == RESULT_ADDR);
  wire logic go_written = ctrl_wr && sfr_req_in.wdata[GO_BIT]; // RULE_04
  wire logic idle = (state_ff == ST_IDLE);

  // A start is honoured only when powered and idle; a start during a running
  // conversion would corrupt the held sample, so it is dropped instead.
  wire logic start_conv = conversion_go_ff && power_on_ff && idle;
  wire logic in_sample = (state_ff == ST_SAMPLE);
  wire logic in_convert = (state_ff == ST_CONVERT);
  wire logic sample_end = in_sample && (cnt_ff == SAMPLE_LAST);
  wire logic step_pulse = in_convert && (cnt_ff == STEP_LAST);

  wire logic [7:0] ctrl_view = {1'b0, power_on_ff, 1'b0, channel_ff,
                                conversion_go_ff, conversion_done_ff};
  wire logic [7:0] result_view = result_value; // RULE_14
  wire logic [7:0] read_mux = ctrl_rd ? ctrl_view :
                              (result_rd ? result_view : 8'h00);

  // Sequencing: sample phase, then one approximation step per interval.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_cnt = '0;
        if (start_conv) begin
          nxt_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (sample_end) begin
          nxt_state = ST_CONVERT;
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      ST_CONVERT: begin
        if (sar_done) begin
          nxt_state = ST_IDLE; // RULE_08
          nxt_cnt = '0;
        end else if (step_pulse) begin
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      sample_hold_ff <= 1'b0;
    end else if (ce_in) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sample_hold_ff <= (nxt_state == ST_SAMPLE);
    end
  end

  // Control fields. Reserved bits are not stored and read back as zero.
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      power_on_ff <= CTRL_RESET[POWER_BIT];
      channel_ff <= CTRL_RESET[CH_LSB +: CH_W];
    end else if (ce_in && ctrl_wr) begin
      power_on_ff <= sfr_req_in.wdata[POWER_BIT];
      channel_ff <= sfr_req_in.wdata[CH_LSB +: CH_W]; // RULE_03
    end
  end

  // The start bit is a one-cycle pulse whatever software does next.
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      conversion_go_ff <= CTRL_RESET[GO_BIT];
    end else if (ce_in) begin
      conversion_go_ff <= go_written && !conversion_go_ff; // RULE_05
    end
  end

  // Done reads zero from the start of a conversion until its completion.
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      conversion_done_ff <= CTRL_RESET[DONE_BIT];
    end else if (ce_in) begin
      if (sar_done) begin
        conversion_done_ff <= 1'b1; // RULE_06
      end else if (start_conv) begin
        conversion_done_ff <= 1'b0; // RULE_07
      end
    end
  end

  // The flag survives interrupt entry; only the clear input removes it, and
  // a completion in the same cycle as a clear keeps it set.
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      converter_irq_flag_ff <= 1'b0;
    end else if (ce_in) begin
      if (sar_done || irq_flag_set_in) begin
        converter_irq_flag_ff <= 1'b1; // RULE_06
      end else if (irq_flag_clear_in) begin
        converter_irq_flag_ff <= 1'b0; // RULE_13
      end
    end
  end

  // Read data is registered; reads never change any state.
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rdata_ff <= 8'h00;
    end else if (ce_in) begin
      rdata_ff <= read_mux;
    end
  end

  adsq_sar #(
    .WIDTH(RES_WIDTH)
  ) u_sar (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .load_in(start_conv),
    .step_in(step_pulse),
    .comp_in(comparator_in),
    .trial_out(trial_code_out),
    .result_out(result_value),
    .done_out(sar_done)
  );

  assign sfr_rdata_out = rdata_ff;
  assign analog_out = '{power_on: power_on_ff, channel: channel_ff};
  assign sample_hold_out = sample_hold_ff;
  assign converter_irq_request_out = converter_irq_flag_ff;
endmodule
`default_nettype wire

// ### tb/adsq_pins.sv
// Analog pin model: one fixed level per input channel.
// Assumes the pins are already in input mode.
`timescale 1ns/1ps
`default_nettype none
module adsq_pins (
  input wire adsq_pkg::adsq_analog_t analog_in,
  input wire logic [7:0] trial_in,
  input wire logic [63:0] levels_in,
  output logic comp_out
);
  import adsq_pkg::*;
  // An unpowered ladder gives no valid compare, so the pin reads low.
  assign comp_out = analog_in.power_on &&
    (levels_in[analog_in.channel*8+:8] >= trial_in);
endmodule
`default_nettype wire

// ### tb/adsq_ctrl_monitor.sv
// Assertions on the sequencer's ports.
// Assumes ce_in stays high while a conversion runs.
`timescale 1ns/1ps
`default_nettype none
module adsq_ctrl_monitor #(
  parameter int unsigned RES_WIDTH = 8,
  parameter int unsigned CHANNELS = 8
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire adsq_pkg::adsq_sfr_req_t sfr_req_in,
  input wire logic irq_flag_set_in,
  input wire logic irq_flag_clear_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire adsq_pkg::adsq_analog_t analog_out,
  input wire logic sample_hold_out,
  input wire logic [RES_WIDTH-1:0] trial_code_out,
  input wire logic converter_irq_request_out
);
  import adsq_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // A request with the clock enable low is not taken, so it is not counted.
  wire ctl_wr = ce_in && sfr_req_in.wr && sfr_req_in.addr == CTRL_ADDR;
  wire ctl_rd = ce_in && sfr_req_in.rd && sfr_req_in.addr == CTRL_ADDR;
  a_sample_len: assert property ($rose(sample_hold_out) |-> ##53 sample_hold_out
    ##1 !sample_hold_out) else $error("sample phase length wrong");
  a_first_trial: assert property ($rose(sample_hold_out) |-> trial_code_out == 8'h80)
    else $error("first trial code wrong");
  a_done_irq: assert property ($rose(sample_hold_out) |-> ##127 converter_irq_request_out)
    else $error("flag not raised at completion");
  a_irq_sticky: assert property (converter_irq_request_out && !irq_flag_clear_in |=>
    converter_irq_request_out) else $error("flag dropped without clear");
  a_irq_set: assert property (ce_in && irq_flag_set_in |=> converter_irq_request_out)
    else $error("flag set ignored");
  a_chan_write: assert property (ctl_wr |=> analog_out == {$past(sfr_req_in.wdata[6]),
    $past(sfr_req_in.wdata[4:2])}) else $error("channel or power wrong");
  a_busy_done: assert property (ctl_rd && sample_hold_out |=> !sfr_rdata_out[0])
    else $error("done set while converting");
  a_go_clears: assert property (ctl_wr ##2 ctl_rd |=> !sfr_rdata_out[1])
    else $error("start bit not cleared");
endmodule
bind adsq_ctrl adsq_ctrl_monitor #(.RES_WIDTH(RES_WIDTH), .CHANNELS(CHANNELS)) mon_inst (
  .clock_in, .resetn_in, .ce_in, .sfr_req_in, .irq_flag_set_in, .irq_flag_clear_in,
  .sfr_rdata_out, .analog_out, .sample_hold_out, .trial_code_out,
  .converter_irq_request_out);
`default_nettype wire

// ### tb/adsq_ctrl_tb.sv
// Self-checking bench for the converter sequencer.
// Assumes the clock enable may stay high for the whole run.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module adsq_ctrl_tb;
  import adsq_pkg::*;
  typedef struct packed {logic [7:0] ctl; logic [7:0] res; logic [7:0] rb;} adsq_row_t;
  adsq_row_t rows [8] = '{24'h425a41, 24'h460045, 24'h4ac349, 24'h4e014d,
    24'h528051, 24'h567f55, 24'h5aff59, 24'h5ea55d};
  logic clock_in = 0, resetn_in = 0, ce = 1, set_i = 0, clr_i = 0, comp, sh, irq;
  logic [7:0] rdata, trial;
  logic [63:0] levels = 64'ha5ff_7f80_01c3_005a;
  adsq_sfr_req_t req = '0;
  adsq_analog_t ana;
  int mismatches = 0, num_checks = 0, n;
  adsq_ctrl adsq_ctrl_inst (.clock_in, .resetn_in, .ce_in(ce), .sfr_req_in(req),
    .comparator_in(comp), .irq_flag_set_in(set_i), .irq_flag_clear_in(clr_i),
    .sfr_rdata_out(rdata), .analog_out(ana), .sample_hold_out(sh),
    .trial_code_out(trial), .converter_irq_request_out(irq));
  adsq_pins adsq_pins_inst (.analog_in(ana), .trial_in(trial), .levels_in(levels),
    .comp_out(comp));
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // An idle edge before each request keeps two calls from driving one signal
  // in the same time step; the answer is still read before the next edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1 req = '{a, d, w, !w};
    @(posedge clock_in);
    #1 req = '0;
  endtask
  task automatic flag(input logic s, input logic c);
    @(posedge clock_in);
    #1 set_i = s;
    clr_i = c;
    @(posedge clock_in);
    #1 {set_i, clr_i} = 2'b00;
  endtask
  // Bounded wait; running out of cycles ends the run as a failure.
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge clock_in);
      #1 n++;
    end
    if (n >= 300) begin
      mismatches++;
      complete_run();
    end
  endtask
  initial begin
    forever #2.5 clock_in = ~clock_in;
  end
  initial begin
    repeat (16) @(posedge clock_in);
    #1 resetn_in = 1;
    @(posedge clock_in);
    #1 `CHK({sh, irq, trial, ana}, 14'h0)
    bus(0, CTRL_ADDR, 0);
    `CHK(rdata, CTRL_RESET)
    foreach (rows[i]) begin
      bus(1, CTRL_ADDR, rows[i].ctl);
      wait_irq();
      `CHK(n, CONV_CYCLES + 2)
      bus(0, RESULT_ADDR, 0);
      `CHK(rdata, rows[i].res)
      bus(0, CTRL_ADDR, 0);
      `CHK(rdata, rows[i].rb)
      flag(0, 1);
    end
    // A second start during a conversion must not restart the count.
    bus(1, CTRL_ADDR, 8'h5e);
    bus(1, CTRL_ADDR, 8'h5e);
    bus(0, CTRL_ADDR, 0);
    `CHK(rdata, 8'h5c)
    bus(0, RESULT_ADDR, 0);
    `CHK(rdata, 8'ha5)
    wait_irq();
    `CHK(n, CONV_CYCLES - 4)
    bus(1, RESULT_ADDR, 8'h3c);
    bus(0, RESULT_ADDR, 0);
    `CHK(rdata, 8'ha5)
    bus(0, 8'h86, 0);
    `CHK(rdata, 8'h00)
    flag(1, 1);
    `CHK(irq, 1'b1)
    flag(0, 1);
    `CHK(irq, 1'b0)
    bus(1, CTRL_ADDR, 8'h02);
    repeat (CONV_CYCLES + 4) @(posedge clock_in);
    #1 `CHK({ana.power_on, sh, irq}, 3'b000)
    // With the clock enable low a write must leave power, channel and sample hold untouched.
    ce = 0;
    bus(1, CTRL_ADDR, 8'h5e);
    `CHK({ana, sh}, 5'h00)
    ce = 1;
    complete_run();
  end
endmodule
`default_nettype wire
